//--- acm_cfg.svh
// Offsets, field positions, reset values and timing counts for the channel mux configuration block.
// Assumes inclusion by bare name from the design file and the testbench.
`ifndef ACM_CFG_SVH
`define ACM_CFG_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define ACM_OFS_CFG1      8'h00
`define ACM_OFS_CFG2      8'h04
`define ACM_OFS_CFG3      8'h08
`define ACM_OFS_STATUS    8'h0C
`define ACM_OFS_MASK      8'h10
`define ACM_OFS_THR_HI    8'h14
`define ACM_OFS_THR_LO    8'h18
`define ACM_OFS_CHAN_BASE 8'h20

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ACM_CH_MUX_MSB    2
`define ACM_CH_GAIN_LSB   4
`define ACM_CFG2_INT_TEST 4
`define ACM_CFG2_AMP      2
`define ACM_CFG3_REF4V    5
`define ACM_ST_DRDY       0
`define ACM_ST_OVER       1
`define ACM_ST_UNDER      2

// ----------------------------------------------------------------
// Mux select codes
// ----------------------------------------------------------------
`define ACM_MUX_SHORT     3'h1
`define ACM_MUX_SUPPLY    3'h3
`define ACM_MUX_TEMP      3'h4
`define ACM_MUX_TEST      3'h5

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define ACM_RST_CFG1      8'h06
`define ACM_RST_CFG2      8'h00
`define ACM_RST_CFG3      8'h00
`define ACM_RST_CHAN      8'h00
`define ACM_RST_THR_HI    24'h7FFFFF
`define ACM_RST_THR_LO    24'h800000

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define ACM_SYS_CLK_HZ    100000000
`define ACM_CONV_CLK_HZ   2048000
`define ACM_CONV_INC      ((64'd`ACM_CONV_CLK_HZ << 32) / 64'd`ACM_SYS_CLK_HZ)
`define ACM_DEC_BASE      11'h010
`define ACM_TEST_DIV_MSB  20

`endif

//--- acm_pkg.sv
// Types shared by the channel mux configuration block.
// Assumes acm_cfg.svh is on the include path.
package acm_pkg;

  typedef enum logic [2:0] {
    ACM_RT_NORMAL,
    ACM_RT_SHORT,
    ACM_RT_TEST,
    ACM_RT_TEMP,
    ACM_RT_SUPPLY_ANA,
    ACM_RT_SUPPLY_DIG
  } acm_route_t;

  typedef struct packed {
    logic [7:0][7:0]      chan;
    logic [7:0]           cfg1;
    logic [7:0]           cfg2;
    logic [7:0]           cfg3;
    logic [2:0]           status;
    logic [2:0]           mask;
    logic [23:0]          thr_hi;
    logic [23:0]          thr_lo;
    acm_route_t [7:0]     route;
    logic [7:0][3:0]      gain;
    logic [6:0]           rate;
    logic                 ref_4v;
    logic [31:0]          acc;
    logic                 conv_clk;
    logic                 mod_phase;
    logic [10:0]          dec_cnt;
    logic                 running;
    logic                 drdy;
    logic [20:0]          tdiv;
    logic                 test_wave;
    logic                 test_wave_n;
    logic                 test_oe_n;
    logic                 test_signal_amplitude;
    logic [31:0]          prdata;
    logic                 pready;
    logic                 pslverr;
    logic                 irq;
  } acm_state_t;

endpackage

//--- acm_top.sv
// Channel input mux configuration, conversion timing, test signal source and range comparators.
// Assumes an APB master on clk_in, synchronous inputs, and an analog fabric that obeys the route codes.
//
// The placing of the registers and the APB interface to the registers are this design's own decisions.
`timescale 1ns/100ps
`include "acm_cfg.svh"

// How it works
// - Select code 001 shorts both amplifier inputs to the reference midpoint.
// - Select code 101 routes the channel to the test signal pair.
// - Select code 100 routes the channel to the temperature sensor.
// - Select code 011 routes the channel to a supply monitor.
// - Supply mode: channels 3 and 4 see digital supply, others analog.
// - Test amplitude and frequency come from the second configuration register.
// - The selected test signal is driven on the two test pins.
// - Clearing the internal test bit releases the test pins.
// - Each channel mux follows only its own settings register.
// - Rate code 000..110 gives 64,32,16,8,4,2,1 kSPS.
// - Channel gain is one of 1, 2, 4, 8 or 12.
// - Internal reference selects 2.4 V or 4 V.
// - A phase accumulator on clk_in produces the 2.048 MHz conversion clock.
// - Conversions run on the start input so shared starts stay in step.
// - Comparators with programmable thresholds flag over and under range.
// - The rate code applies to all eight channels together.
module acm_top (
  input  wire logic                      clk_in,
  input  wire logic                      reset_in,
  input  wire logic                      psel_in,
  input  wire logic                      penable_in,
  input  wire logic                      pwrite_in,
  input  wire logic [7:0]                paddr_in,
  input  wire logic [31:0]               pwdata_in,
  output logic      [31:0]               prdata_out,
  output logic                           pready_out,
  output logic                           pslverr_out,
  output logic                           irq_out,
  input  wire logic                      start_in,
  input  wire logic                      sample_valid_in,
  input  wire logic [23:0]               sample_data_in,
  output acm_pkg::acm_route_t [7:0]      channel_route_out,
  output logic      [31:0]               channel_gain_out,
  output logic      [2:0]                data_rate_code_out,
  output logic      [6:0]                data_rate_ksps_out,
  output logic                           ref_4v_out,
  output logic                           conv_clk_out,
  output logic                           drdy_out,
  input  wire logic                      test_signal_positive_pin_in,
  input  wire logic                      test_signal_negative_pin_in,
  output logic                           test_signal_positive_pin_out,
  output logic                           test_signal_negative_pin_out,
  output logic                           test_signal_pin_oe_n_out,
  output logic                           test_signal_amplitude_out
);
  import acm_pkg::*;

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic acm_route_t route_of(input logic [2:0] sel, input int ch);
    acm_route_t r;
    r = ACM_RT_NORMAL;
    case (sel)
      `ACM_MUX_SHORT:  r = ACM_RT_SHORT;
      `ACM_MUX_TEST:   r = ACM_RT_TEST;
      `ACM_MUX_TEMP:   r = ACM_RT_TEMP;
      `ACM_MUX_SUPPLY: begin
        // Zero-based 2 and 3 are channels 3 and 4
        r = (ch == 2 || ch == 3) ? ACM_RT_SUPPLY_DIG : ACM_RT_SUPPLY_ANA;
      end
      default:         r = ACM_RT_NORMAL;
    endcase
    return r;
  endfunction

  // Codes 5 to 7 have no gain of their own; fall back to unity
  function automatic logic [3:0] gain_of(input logic [2:0] code);
    logic [3:0] g;
    g = 4'h1;
    case (code)
      3'h0:    g = 4'h1;
      3'h1:    g = 4'h2;
      3'h2:    g = 4'h4;
      3'h3:    g = 4'h8;
      3'h4:    g = 4'hC;
      default: g = 4'h1;
    endcase
    return g;
  endfunction

  // Code 111 is unlisted and runs at the slowest rate
  function automatic logic [6:0] rate_of(input logic [2:0] dr);
    logic [6:0] r;
    r = 7'h01;
    if (dr != 3'h7) begin
      r = 7'h40 >> dr;
    end
    return r;
  endfunction

  function automatic logic [10:0] decim_of(input logic [2:0] dr);
    logic [10:0] d;
    d = (dr == 3'h7) ? (`ACM_DEC_BASE << 6) : (`ACM_DEC_BASE << dr);
    return d;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  acm_state_t state;
  acm_state_t next_state;

  logic [31:0] conv_inc;
  assign conv_inc = 32'(`ACM_CONV_INC);

  always_comb begin
    logic        setup;
    logic        access;
    logic        wr;
    logic [31:0] rd;
    logic        bad;
    logic [2:0]  events;
    logic [2:0]  w1c;
    logic [32:0] sum;
    logic        conv_rise;
    logic        mod_tick;
    logic [2:0]  idx;
    setup     = 1'b0;
    access    = 1'b0;
    wr        = 1'b0;
    rd        = 32'h00000000;
    bad       = 1'b0;
    events    = 3'h0;
    w1c       = 3'h0;
    sum       = 33'h000000000;
    conv_rise = 1'b0;
    mod_tick  = 1'b0;
    idx       = 3'h0;
    next_state = state;

    // ----------------------------------------------------------------
    // APB slave: zero wait state, decode in setup, answer in access
    // ----------------------------------------------------------------
    setup  = psel_in && !penable_in;
    access = psel_in && penable_in && state.pready;
    wr     = access && pwrite_in;
    idx    = paddr_in[4:2];

    if (paddr_in[1:0] != 2'h0) begin
      bad = 1'b1;
    end else if (paddr_in >= `ACM_OFS_CHAN_BASE && paddr_in < 8'h40) begin
      rd = {24'h000000, state.chan[idx]};
    end else begin
      case (paddr_in)
        `ACM_OFS_CFG1:   rd = {24'h000000, state.cfg1};
        `ACM_OFS_CFG2:   rd = {24'h000000, test_signal_positive_pin_in,
                               test_signal_negative_pin_in, state.cfg2[5:0]};
        `ACM_OFS_CFG3:   rd = {24'h000000, state.cfg3};
        `ACM_OFS_STATUS: rd = {29'h00000000, state.status};
        `ACM_OFS_MASK:   rd = {29'h00000000, state.mask};
        `ACM_OFS_THR_HI: rd = {8'h00, state.thr_hi};
        `ACM_OFS_THR_LO: rd = {8'h00, state.thr_lo};
        default:         bad = 1'b1;
      endcase
    end

    next_state.pready = setup;
    if (setup) begin
      next_state.prdata  = pwrite_in ? 32'h00000000 : rd;
      next_state.pslverr = bad;
    end else if (access) begin
      next_state.prdata  = 32'h00000000;
      next_state.pslverr = 1'b0;
    end

    if (wr && !bad) begin
      if (paddr_in >= `ACM_OFS_CHAN_BASE) begin
        next_state.chan[idx] = pwdata_in[7:0];
      end else begin
        case (paddr_in)
          `ACM_OFS_CFG1:   next_state.cfg1   = pwdata_in[7:0];
          `ACM_OFS_CFG2:   next_state.cfg2   = {2'h0, pwdata_in[5:0]};
          `ACM_OFS_CFG3:   next_state.cfg3   = pwdata_in[7:0];
          `ACM_OFS_STATUS: w1c               = pwdata_in[2:0];
          `ACM_OFS_MASK:   next_state.mask   = pwdata_in[2:0];
          `ACM_OFS_THR_HI: next_state.thr_hi = pwdata_in[23:0];
          `ACM_OFS_THR_LO: next_state.thr_lo = pwdata_in[23:0];
          default:         next_state.mask   = state.mask;
        endcase
      end
    end

    // ----------------------------------------------------------------
    // Per-channel routing and gain, each from its own register only
    // ----------------------------------------------------------------
    for (int ch = 0; ch < 8; ch++) begin
      next_state.route[ch] = route_of(state.chan[ch][`ACM_CH_MUX_MSB:0], ch);
      next_state.gain[ch]  = gain_of(state.chan[ch][`ACM_CH_GAIN_LSB+2:`ACM_CH_GAIN_LSB]);
    end
    next_state.rate   = rate_of(state.cfg1[2:0]);
    next_state.ref_4v = state.cfg3[`ACM_CFG3_REF4V];

    // ----------------------------------------------------------------
    // Conversion clock: phase accumulator, since 100 MHz is no
    // integer multiple of 2.048 MHz; edges jitter by one system cycle
    // ----------------------------------------------------------------
    sum                 = {1'b0, state.acc} + {1'b0, conv_inc};
    next_state.acc      = sum[31:0];
    next_state.conv_clk = sum[31];
    conv_rise           = sum[31] && !state.conv_clk;
    if (conv_rise) begin
      next_state.mod_phase = !state.mod_phase;
    end
    mod_tick = conv_rise && state.mod_phase;

    // ----------------------------------------------------------------
    // Decimation: one result per modulator ticks of the global rate
    // ----------------------------------------------------------------
    next_state.drdy    = 1'b0;
    next_state.running = start_in;
    if (!start_in) begin
      // Restarting from zero keeps devices sharing a start in step
      next_state.dec_cnt = 11'h000;
    end else if (mod_tick) begin
      if (state.dec_cnt >= decim_of(state.cfg1[2:0]) - 11'h001) begin
        next_state.dec_cnt = 11'h000;
        next_state.drdy    = state.running;
      end else begin
        next_state.dec_cnt = state.dec_cnt + 11'h001;
      end
    end

    // ----------------------------------------------------------------
    // Test signal: 00 slow, 01 fast square wave, 11 DC high, 10 hold
    // ----------------------------------------------------------------
    if (conv_rise) begin
      next_state.tdiv = state.tdiv + 21'h000001;
    end
    case (state.cfg2[1:0])
      2'h0:    next_state.test_wave = state.tdiv[`ACM_TEST_DIV_MSB];
      2'h1:    next_state.test_wave = state.tdiv[`ACM_TEST_DIV_MSB-1];
      2'h3:    next_state.test_wave = 1'b1;
      default: next_state.test_wave = state.test_wave;
    endcase
    next_state.test_wave_n = !next_state.test_wave;
    next_state.test_signal_amplitude  = state.cfg2[`ACM_CFG2_AMP];
    // Pins are released so an outside source can drive them
    next_state.test_oe_n = !state.cfg2[`ACM_CFG2_INT_TEST];

    // ----------------------------------------------------------------
    // Range comparators on the incoming sample stream
    // ----------------------------------------------------------------
    if (sample_valid_in) begin
      events[`ACM_ST_OVER]  = $signed(sample_data_in) > $signed(state.thr_hi);
      events[`ACM_ST_UNDER] = $signed(sample_data_in) < $signed(state.thr_lo);
    end
    events[`ACM_ST_DRDY] = next_state.drdy;

    // Set wins over a same-cycle clear
    next_state.status = (state.status & ~w1c) | events;
    next_state.irq    = |(next_state.status & next_state.mask);
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      state           <= '0;
      state.chan      <= {8{`ACM_RST_CHAN}};
      state.cfg1      <= `ACM_RST_CFG1;
      state.cfg2      <= `ACM_RST_CFG2;
      state.cfg3      <= `ACM_RST_CFG3;
      state.thr_hi    <= `ACM_RST_THR_HI;
      state.thr_lo    <= `ACM_RST_THR_LO;
      state.route     <= '{default: ACM_RT_NORMAL};
      state.gain      <= {8{4'h1}};
      state.rate      <= 7'h01;
      state.test_oe_n <= 1'b1;
      state.test_wave_n <= 1'b1;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all taken straight from the state register
  // ----------------------------------------------------------------
  assign prdata_out                   = state.prdata;
  assign pready_out                   = state.pready;
  assign pslverr_out                  = state.pslverr;
  assign irq_out                      = state.irq;
  assign channel_route_out            = state.route;
  assign channel_gain_out             = state.gain;
  assign data_rate_code_out           = state.cfg1[2:0];
  assign data_rate_ksps_out           = state.rate;
  assign ref_4v_out                   = state.ref_4v;
  assign conv_clk_out                 = state.conv_clk;
  assign drdy_out                     = state.drdy;
  assign test_signal_positive_pin_out = state.test_wave;
  assign test_signal_negative_pin_out = state.test_wave_n;
  assign test_signal_pin_oe_n_out     = state.test_oe_n;
  assign test_signal_amplitude_out    = state.test_signal_amplitude;

endmodule

//--- acm_asserts.sv
// Checker for the channel mux block: routes, gains, rate table, test pins and conversion timing.
// Assumes it is bound to acm_top and sees only that module's ports.
`timescale 1ns/100ps
module acm_asserts
  import acm_pkg::*;
(
  input wire logic                        clk_in,
  input wire logic                        reset_in,
  input wire logic                        psel_in,
  input wire logic                        penable_in,
  input wire logic                        pwrite_in,
  input wire logic [7:0]                  paddr_in,
  input wire logic [31:0]                 pwdata_in,
  input wire logic                        pready_out,
  input wire logic                        start_in,
  input wire acm_pkg::acm_route_t [7:0]   channel_route_out,
  input wire logic [31:0]                 channel_gain_out,
  input wire logic [2:0]                  data_rate_code_out,
  input wire logic [6:0]                  data_rate_ksps_out,
  input wire logic                        conv_clk_out,
  input wire logic                        drdy_out,
  input wire logic                        test_signal_positive_pin_out,
  input wire logic                        test_signal_negative_pin_out,
  input wire logic                        test_signal_pin_oe_n_out
);
  // ----------------------------------------------------------------
  // Helper logic
  // ----------------------------------------------------------------
  logic            wr_q;
  logic            conv_q;
  logic [5:0]      run_len;
  logic [7:0]      addr_q;
  logic [31:0]     data_q;
  wire logic       chan_wr = wr_q && addr_q[7:5] == 3'h1 && addr_q[1:0] == 2'h0;
  wire logic [2:0] wch     = addr_q[4:2];

  // Address is captured only on writes so it still names the channel two edges later
  always_ff @(posedge clk_in) begin
    wr_q    <= !reset_in && psel_in && penable_in && pready_out && pwrite_in;
    conv_q  <= conv_clk_out;
    run_len <= (reset_in || conv_clk_out != conv_q) ? 6'h00 : run_len + 6'h01;
    if (psel_in && penable_in && pwrite_in) begin
      addr_q <= paddr_in;
      data_q <= pwdata_in;
    end
  end

  function automatic logic [3:0] gain_of(input logic [2:0] code);
    return (code == 3'h4) ? 4'hC : (code < 3'h4) ? (4'h1 << code) : 4'h1;
  endfunction

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  property p_short;
    @(posedge clk_in) disable iff (reset_in) chan_wr && data_q[2:0] == 3'h1 |=> channel_route_out[wch] == ACM_RT_SHORT;
  endproperty
  a_short: assert property (p_short) else $error("short select not routed");
  property p_test;
    @(posedge clk_in) disable iff (reset_in) chan_wr && data_q[2:0] == 3'h5 |=> channel_route_out[wch] == ACM_RT_TEST;
  endproperty
  a_test: assert property (p_test) else $error("test select not routed");
  property p_supply;
    @(posedge clk_in) disable iff (reset_in) chan_wr && data_q[2:0] == 3'h3 |=> channel_route_out[wch] ==
      ((wch == 3'h2 || wch == 3'h3) ? ACM_RT_SUPPLY_DIG : ACM_RT_SUPPLY_ANA);
  endproperty
  a_supply: assert property (p_supply) else $error("supply monitor route wrong");
  property p_gain;
    @(posedge clk_in) disable iff (reset_in) chan_wr |=> channel_gain_out[{wch, 2'b00} +: 4] == gain_of(data_q[6:4]);
  endproperty
  a_gain: assert property (p_gain) else $error("channel gain wrong");
  property p_rate;
    @(posedge clk_in) disable iff (reset_in)
      data_rate_ksps_out == (($past(data_rate_code_out) == 3'h7) ? 7'h01 : (7'h40 >> $past(data_rate_code_out)));
  endproperty
  a_rate: assert property (p_rate) else $error("rate code and rate disagree");
  property p_comp;
    @(posedge clk_in) disable iff (reset_in)
      !test_signal_pin_oe_n_out |-> test_signal_positive_pin_out != test_signal_negative_pin_out;
  endproperty
  a_comp: assert property (p_comp) else $error("test pins not complementary");
  property p_start;
    @(posedge clk_in) disable iff (reset_in) !start_in && !$past(start_in) |-> !drdy_out;
  endproperty
  a_start: assert property (p_start) else $error("result ready while stopped");
  property p_conv;
    @(posedge clk_in) disable iff (reset_in) run_len < 6'd27;
  endproperty
  a_conv: assert property (p_conv) else $error("conversion clock half period too long");
endmodule

//--- tb.sv
// Self-checking bench for the channel mux block, driving APB, start, samples and test pins.
// Assumes acm_pkg, acm_top and acm_asserts are compiled first and acm_cfg.svh is on the include path.
`timescale 1ns/100ps
`include "acm_cfg.svh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin num_errors++; \
  $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module tb;
  import acm_pkg::*;
  logic             clk_in = 1'b0;
  logic             reset_in = 1'b1;
  logic             psel = 1'b0, penable = 1'b0, pwrite = 1'b0, start = 1'b0, svalid = 1'b0;
  logic             tp_in = 1'b0, tn_in = 1'b0;
  logic [7:0]       paddr = 8'h00;
  logic [31:0]      pwdata = 32'h0, prdata, rd, gain, exp_gain;
  logic [23:0]      sdata = 24'h0;
  logic             pready, pslverr, irq, ref_4v, conv_clk, drdy, tp_out, tn_out, oe_n, amp, err;
  acm_route_t [7:0] route, exp_route;
  logic [2:0]       rate_code;
  logic [6:0]       ksps;
  logic [3:0]       gain_tab [8] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'hC, 4'h1, 4'h1, 4'h1};
  logic [6:0]       ksps_tab [8] = '{7'h40, 7'h20, 7'h10, 7'h08, 7'h04, 7'h02, 7'h01, 7'h01};
  int               num_errors = 0;
  int               tests_run = 0;

  always #5 clk_in = ~clk_in;

  acm_top dut (
    .clk_in(clk_in), .reset_in(reset_in), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
    .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .irq_out(irq), .start_in(start), .sample_valid_in(svalid), .sample_data_in(sdata),
    .channel_route_out(route), .channel_gain_out(gain), .data_rate_code_out(rate_code),
    .data_rate_ksps_out(ksps), .ref_4v_out(ref_4v), .conv_clk_out(conv_clk), .drdy_out(drdy),
    .test_signal_positive_pin_in(tp_in), .test_signal_negative_pin_in(tn_in),
    .test_signal_positive_pin_out(tp_out), .test_signal_negative_pin_out(tn_out),
    .test_signal_pin_oe_n_out(oe_n), .test_signal_amplitude_out(amp));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic end_sim;
    $display("Comparisons %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic settle;
    repeat (3) @(negedge clk_in);
  endtask

  // Request holds until the rising edge at which pready is sampled high; the answer is taken there
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_in);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      num_errors++;
      end_sim();
    end
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic count(output int rises);
    logic prev;
    int   n;
    rises = 0;
    n     = 0;
    prev  = conv_clk;
    do begin
      @(negedge clk_in);
      rises += int'(conv_clk === 1'b1 && prev === 1'b0);
      prev = conv_clk;
      n++;
    end while (drdy !== 1'b1 && n < 20000);
    if (drdy !== 1'b1) begin
      num_errors++;
      end_sim();
    end
  endtask

  task automatic sample(input logic [23:0] v);
    @(posedge clk_in);
    svalid <= 1'b1;
    sdata  <= v;
    @(posedge clk_in);
    svalid <= 1'b0;
    settle();
  endtask

  function automatic acm_route_t exp_rt(input int ch, input logic [2:0] code);
    case (code)
      3'h1: exp_rt = ACM_RT_SHORT;
      3'h3: exp_rt = (ch == 2 || ch == 3) ? ACM_RT_SUPPLY_DIG : ACM_RT_SUPPLY_ANA;
      3'h4: exp_rt = ACM_RT_TEMP;
      3'h5: exp_rt = ACM_RT_TEST;
      default: exp_rt = ACM_RT_NORMAL;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    foreach (exp_route[i]) exp_route[i] = ACM_RT_NORMAL;
    exp_gain = 32'h11111111;
    `CHK(route, exp_route)
    `CHK(gain, exp_gain)
    `CHK(oe_n, 1'b1)
    apb(1'b0, `ACM_OFS_CFG1, 32'h0);
    `CHK(rd, 32'h6)
    apb(1'b0, `ACM_OFS_THR_HI, 32'h0);
    `CHK(rd, 32'h007FFFFF)
    apb(1'b0, 8'h1C, 32'h0);
    `CHK(err, 1'b1)
  endtask

  // Every select code on every channel; the untouched channels must not move
  task automatic t_mux;
    logic [2:0] g;
    for (int ch = 0; ch < 8; ch++) begin
      for (int c = 0; c < 8; c++) begin
        g = (c == 3) ? 3'h0 : 3'(ch + c);
        apb(1'b1, 8'(`ACM_OFS_CHAN_BASE + 4 * ch), {25'h0, g, 1'b0, 3'(c)});
        exp_route[ch] = exp_rt(ch, 3'(c));
        exp_gain[4 * ch +: 4] = gain_tab[g];
        settle();
        `CHK(route, exp_route)
        `CHK(gain, exp_gain)
      end
    end
  endtask

  task automatic t_rate;
    int rises;
    int n;
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, `ACM_OFS_CFG1, 32'(c));
      settle();
      `CHK(rate_code, 3'(c))
      `CHK(ksps, ksps_tab[c])
    end
    for (int c = 0; c < 2; c++) begin
      apb(1'b1, `ACM_OFS_CFG1, 32'(c));
      start <= 1'b1;
      count(rises);
      count(rises);
      `CHK(rises, 32 << c)
      @(posedge clk_in);
      start <= 1'b0;
    end
    repeat (3) @(negedge clk_in);
    n = 0;
    repeat (2000) begin
      @(negedge clk_in);
      n += int'(drdy === 1'b1);
    end
    `CHK(n, 0)
  endtask

  task automatic t_irq;
    apb(1'b1, `ACM_OFS_MASK, 32'h0);
    apb(1'b1, `ACM_OFS_STATUS, 32'h7);
    // Host threshold at 100 degrees, in microvolts
    apb(1'b1, `ACM_OFS_THR_HI, 32'(144000 + 400 * 100));
    apb(1'b1, `ACM_OFS_THR_LO, 32'h00FFFF00);
    apb(1'b1, `ACM_OFS_MASK, 32'h6);
    sample(24'(144000 + 400 * 101));
    `CHK(irq, 1'b1)
    apb(1'b1, `ACM_OFS_MASK, 32'h0);
    settle();
    `CHK(irq, 1'b0)
    apb(1'b1, `ACM_OFS_STATUS, 32'h2);
    sample(24'hFFF000);
    apb(1'b0, `ACM_OFS_STATUS, 32'h0);
    `CHK(rd, 32'h4)
    apb(1'b1, `ACM_OFS_STATUS, 32'h4);
    sample(24'h000050);
    apb(1'b0, `ACM_OFS_STATUS, 32'h0);
    `CHK(rd, 32'h0)
  endtask

  task automatic t_test;
    apb(1'b1, `ACM_OFS_CFG2, 32'h10);
    settle();
    `CHK(oe_n, 1'b0)
    `CHK(tp_out ^ tn_out, 1'b1)
    apb(1'b1, `ACM_OFS_CFG2, 32'h17);
    settle();
    `CHK(amp, 1'b1)
    `CHK({tp_out, tn_out}, 2'b10)
    apb(1'b1, `ACM_OFS_CFG2, 32'h0);
    tp_in <= 1'b1;
    settle();
    `CHK(oe_n, 1'b1)
    apb(1'b0, `ACM_OFS_CFG2, 32'h0);
    `CHK(rd, 32'h80)
    apb(1'b1, `ACM_OFS_CFG3, 32'h20);
    settle();
    `CHK(ref_4v, 1'b1)
    apb(1'b1, `ACM_OFS_CFG3, 32'h0);
    settle();
    `CHK(ref_4v, 1'b0)
  endtask

  initial begin
    repeat (20) @(posedge clk_in);
    reset_in <= 1'b0;
    settle();
    t_reset();
    t_mux();
    t_rate();
    t_irq();
    t_test();
    end_sim();
  end
endmodule

bind acm_top acm_asserts u_chk (
  .clk_in(clk_in), .reset_in(reset_in), .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
  .paddr_in(paddr_in), .pwdata_in(pwdata_in), .pready_out(pready_out), .start_in(start_in),
  .channel_route_out(channel_route_out), .channel_gain_out(channel_gain_out),
  .data_rate_code_out(data_rate_code_out), .data_rate_ksps_out(data_rate_ksps_out),
  .conv_clk_out(conv_clk_out), .drdy_out(drdy_out), .test_signal_positive_pin_out(test_signal_positive_pin_out),
  .test_signal_negative_pin_out(test_signal_negative_pin_out), .test_signal_pin_oe_n_out(test_signal_pin_oe_n_out));
